// file: lim_datapath.sv
// Logic and internal-move execution datapath with its sequencer
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - AND, OR, XOR act bit by bit; each result bit uses its own position.
// - Accumulator-destination logic takes direct, indirect, register or immediate operand.
// - Logic into a direct byte uses accumulator or immediate, accumulator unchanged.
// - Plain rotates move accumulator one bit; end bit wraps around.
// - Carry rotates pass the carry flag through the one-bit rotation.
// - Nibble swap exchanges accumulator halves and changes nothing else.
// - Transfer copies a byte between internal locations, accumulator untouched unless it is the destination.
// - Upper RAM only indirectly; direct addresses there select special-function space.
// - Special-function space only direct; indirect never reaches it.
// - Stack grows up; save increments pointer first, then writes there.
// - Stack operands are direct; stack itself is RAM through the pointer.
// - One operation loads the whole 16-bit data pointer.
// - Exchange swaps whole accumulator and addressed byte.
// - Low-nibble exchange through an indirect pointer swaps only low nibbles.
module lim_datapath
  import lim_pkg::*;
#(
  parameter int RAM_DEPTH = RAM_BYTES
) (
  input wire logic clk, // Core clock
  input wire logic arst_n, // Async reset, active low
  input wire logic cmdValid, // Command offered
  output logic cmdReady, // Sequencer idle
  input wire lim_op_t cmdOp, // Operation
  input wire lim_mode_t srcMode, // Source operand mode
  input wire logic [BYTE_W-1:0] srcVal, // Source address, register or constant
  input wire lim_mode_t dstMode, // Destination operand mode
  input wire logic [BYTE_W-1:0] dstVal, // Destination address or register
  input wire logic [WORD_W-1:0] immWord, // Constant for data pointer load
  input wire logic [BANK_W-1:0] bankSel, // Working register bank
  output logic [BYTE_W-1:0] sfrAddr, // Special-function address
  output logic sfrRdEn, // Special-function read strobe
  output logic sfrWrEn, // Special-function write strobe
  output logic [BYTE_W-1:0] sfrWrData, // Special-function write byte
  input wire logic [BYTE_W-1:0] sfrRdData, // Read byte, cycle after strobe
  output logic [BYTE_W-1:0] accOut, // Accumulator
  output logic carryOut, // Carry flag
  output logic [BYTE_W-1:0] stackPointerOut, // Stack pointer
  output logic [WORD_W-1:0] dataPointerOut, // Data pointer
  output logic doneOut, // Command finished, one cycle
  output logic errorOut // Command refused, high the cycle after each idle cycle a refused command is offered
);
  typedef enum logic [2:0] {S_IDLE, S_SPTR, S_SRD, S_DATA_POINTER, S_DRD, S_EXE} lim_state_t;

  lim_state_t state_r, stateNxt;
  lim_op_t op_r;
  lim_mode_t srcMd_r, dstMd_r, effSrc, effDst;
  logic [BYTE_W-1:0] srcVal_r, dstVal_r, dstPtr_r, srcByte_r, acc_r, sp_r;
  logic [BYTE_W-1:0] accNxt, spNxt, memByte, srcB, dstB, logicRes, spInc;
  logic [BYTE_W-1:0] srcLoc, dstLoc, dstPtrNow, sfrAddrNxt;
  logic [WORD_W-1:0] dp_r, imm_r;
  logic [BANK_W-1:0] bank_r;
  logic carry_r, carryNxt, done_r, err_r, cmdBad, take;
  logic srcIsSfr, dstIsSfr, dstRead, needWrite, toRam, toSfr, sfrRdNxt;
  logic sfrRdEn_r, sfrWrEn_r;
  logic [BYTE_W-1:0] sfrAddr_r, sfrWrData_r;

  lim_ram_if ram ();

  lim_ram #(.DEPTH(RAM_DEPTH)) u_ram (
    .clk(clk),
    .port(ram)
  );

  function automatic logic [BYTE_W-1:0] regAddr(logic [BANK_W-1:0] b,
                                                logic [REG_IDX_W-1:0] i);
    return {{(BYTE_W-BANK_W-REG_IDX_W){1'b0}}, b, i};
  endfunction

  // Stack commands imply their far operand, always RAM through the pointer
  assign effSrc = (cmdOp == STACK_RESTORE_OP) ? MD_STK : srcMode;
  assign effDst = (cmdOp == STACK_SAVE_OP) ? MD_STK : dstMode;

  // Legal operand combinations; anything else is refused at the port
  always_comb begin
    cmdBad = 1'b0;
    unique case (cmdOp)
      AND_OP, OR_OP, XOR_OP: begin
        cmdBad = !((dstMode == MD_ACC && srcMode inside {MD_DIR, MD_IND, MD_REG, MD_IMM})
          || (dstMode == MD_DIR && srcMode inside {MD_ACC, MD_IMM}));
      end
      TRANSFER_OP: begin
        cmdBad = dstMode inside {MD_NONE, MD_IMM, MD_STK} || srcMode inside {MD_NONE, MD_STK};
      end
      STACK_SAVE_OP: cmdBad = srcMode != MD_DIR;
      STACK_RESTORE_OP: cmdBad = dstMode != MD_DIR;
      EXCHANGE_OP: cmdBad = !(dstMode inside {MD_DIR, MD_IND, MD_REG});
      EXCHANGE_LOW_NIBBLE_OP: cmdBad = dstMode != MD_IND;
      default: cmdBad = 1'b0;
    endcase
  end

  assign cmdReady = (state_r == S_IDLE);
  assign take = cmdReady && cmdValid && !cmdBad;

  // Fixed five-cycle walk keeps timing independent of addressing mode
  always_comb begin
    unique case (state_r)
      S_IDLE: stateNxt = take ? S_SPTR : S_IDLE;
      S_SPTR: stateNxt = S_SRD;
      S_SRD: stateNxt = S_DATA_POINTER;
      S_DATA_POINTER: stateNxt = S_DRD;
      S_DRD: stateNxt = S_EXE;
      S_EXE: stateNxt = S_IDLE;
      // Spare codes of the state register fall back to idle
      default: stateNxt = S_IDLE;
    endcase
  end

  // Only direct addresses in the upper half reach special-function space
  assign srcIsSfr = (srcMd_r == MD_DIR) && srcVal_r[UPPER_BIT];
  assign dstIsSfr = (dstMd_r == MD_DIR) && dstVal_r[UPPER_BIT];
  assign dstRead = op_r inside {AND_OP, OR_OP, XOR_OP, EXCHANGE_OP, EXCHANGE_LOW_NIBBLE_OP};
  assign needWrite = (op_r inside {STACK_SAVE_OP, STACK_RESTORE_OP, EXCHANGE_OP,
    EXCHANGE_LOW_NIBBLE_OP}) || (op_r inside {AND_OP, OR_OP, XOR_OP, TRANSFER_OP}
    && dstMd_r != MD_ACC);
  assign toSfr = needWrite && dstIsSfr;
  assign toRam = needWrite && !dstIsSfr;

  // Location decode; indirect and stack forms always land in RAM
  assign spInc = sp_r + SP_STEP;
  assign dstPtrNow = (state_r == S_DRD) ? ram.rdData : dstPtr_r;
  assign srcLoc = (srcMd_r == MD_IND) ? ram.rdData :
    (srcMd_r == MD_REG) ? regAddr(bank_r, srcVal_r[REG_IDX_W-1:0]) :
    (srcMd_r == MD_STK) ? sp_r : srcVal_r;
  assign dstLoc = (dstMd_r == MD_IND) ? dstPtrNow :
    (dstMd_r == MD_REG) ? regAddr(bank_r, dstVal_r[REG_IDX_W-1:0]) :
    (dstMd_r == MD_STK) ? spInc : dstVal_r;

  // RAM address per step: pointer register, source, pointer register, destination
  always_comb begin
    unique case (state_r)
      S_SPTR: ram.addr = regAddr(bank_r, srcVal_r[REG_IDX_W-1:0] & IND_REG_MASK);
      S_SRD: ram.addr = srcLoc;
      S_DATA_POINTER: ram.addr = regAddr(bank_r, dstVal_r[REG_IDX_W-1:0] & IND_REG_MASK);
      default: ram.addr = dstLoc;
    endcase
  end
  assign ram.wrEn = (state_r == S_EXE) && toRam;
  assign ram.wrData = memByte;

  // Operand values seen in the execute step
  assign srcB = (srcMd_r == MD_IMM) ? srcVal_r : (srcMd_r == MD_ACC) ? acc_r : srcByte_r;
  assign dstB = (dstMd_r == MD_ACC) ? acc_r : dstIsSfr ? sfrRdData : ram.rdData;
  assign logicRes = (op_r == AND_OP) ? (dstB & srcB) :
    (op_r == OR_OP) ? (dstB | srcB) : (dstB ^ srcB);

  // Result selection; accumulator and flags change only where the operation says
  always_comb begin
    accNxt = acc_r;
    carryNxt = carry_r;
    spNxt = sp_r;
    memByte = srcB;
    unique case (op_r)
      AND_OP, OR_OP, XOR_OP: begin
        if (dstMd_r == MD_ACC) begin
          accNxt = logicRes;
        end else begin
          memByte = logicRes;
        end
      end
      CLEAR_OP: accNxt = ACC_CLEAR;
      COMPLEMENT_OP: accNxt = ~acc_r;
      ROTATE_LEFT_OP: accNxt = {acc_r[BYTE_W-2:0], acc_r[BYTE_W-1]};
      ROTATE_RIGHT_OP: accNxt = {acc_r[0], acc_r[BYTE_W-1:1]};
      ROTATE_LEFT_CARRY_OP: {carryNxt, accNxt} = {acc_r, carry_r};
      ROTATE_RIGHT_CARRY_OP: {accNxt, carryNxt} = {carry_r, acc_r};
      SWAP_NIBBLE_OP: accNxt = {acc_r[NIB_W-1:0], acc_r[BYTE_W-1:NIB_W]};
      TRANSFER_OP: begin
        if (dstMd_r == MD_ACC) begin
          accNxt = srcB;
        end else begin
          memByte = srcB;
        end
      end
      STACK_SAVE_OP: spNxt = spInc;
      STACK_RESTORE_OP: spNxt = sp_r - SP_STEP;
      LOAD_DATA_POINTER_OP: accNxt = acc_r;
      EXCHANGE_OP: begin
        memByte = acc_r;
        accNxt = dstB;
      end
      EXCHANGE_LOW_NIBBLE_OP: begin
        memByte = {dstB[BYTE_W-1:NIB_W], acc_r[NIB_W-1:0]};
        accNxt = {acc_r[BYTE_W-1:NIB_W], dstB[NIB_W-1:0]};
      end
    endcase
  end

  // Special-function strobes are registered so the bus sees clean edges
  assign sfrRdNxt = (stateNxt == S_SRD && srcIsSfr) || (stateNxt == S_DRD && dstIsSfr && dstRead);
  assign sfrAddrNxt = (stateNxt == S_SRD) ? srcVal_r : dstVal_r;

  // Command latch and sequencer state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_IDLE;
      op_r <= AND_OP;
      srcMd_r <= MD_NONE;
      dstMd_r <= MD_NONE;
      srcVal_r <= ACC_RESET;
      dstVal_r <= ACC_RESET;
      imm_r <= DP_RESET;
      bank_r <= '0;
    end else begin
      state_r <= stateNxt;
      if (take) begin
        op_r <= cmdOp;
        srcMd_r <= effSrc;
        dstMd_r <= effDst;
        srcVal_r <= srcVal;
        dstVal_r <= dstVal;
        imm_r <= immWord;
        bank_r <= bankSel;
      end
    end
  end

  // Operand captures; a source byte never passes through the accumulator
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      srcByte_r <= ACC_RESET;
      dstPtr_r <= ACC_RESET;
    end else begin
      if (state_r == S_DATA_POINTER) begin
        srcByte_r <= srcIsSfr ? sfrRdData : ram.rdData;
      end
      if (state_r == S_DRD) begin
        dstPtr_r <= ram.rdData;
      end
    end
  end

  // Architectural state, committed at the end of the execute step
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_r <= ACC_RESET;
      carry_r <= CARRY_RESET;
      sp_r <= SP_RESET;
      dp_r <= DP_RESET;
    end else if (state_r == S_EXE) begin
      acc_r <= accNxt;
      carry_r <= carryNxt;
      sp_r <= spNxt;
      if (op_r == LOAD_DATA_POINTER_OP) begin
        dp_r <= imm_r;
      end
    end
  end

  // Pulses and the special-function bus
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_r <= 1'b0;
      err_r <= 1'b0;
      sfrRdEn_r <= 1'b0;
      sfrWrEn_r <= 1'b0;
      sfrAddr_r <= ACC_RESET;
      sfrWrData_r <= ACC_RESET;
    end else begin
      done_r <= (state_r == S_EXE);
      err_r <= cmdReady && cmdValid && cmdBad;
      sfrRdEn_r <= sfrRdNxt;
      sfrWrEn_r <= (state_r == S_EXE) && toSfr;
      sfrAddr_r <= sfrAddrNxt;
      sfrWrData_r <= memByte;
    end
  end

  assign accOut = acc_r;
  assign carryOut = carry_r;
  assign stackPointerOut = sp_r;
  assign dataPointerOut = dp_r;
  assign doneOut = done_r;
  assign errorOut = err_r;
  assign sfrAddr = sfrAddr_r;
  assign sfrRdEn = sfrRdEn_r;
  assign sfrWrEn = sfrWrEn_r;
  assign sfrWrData = sfrWrData_r;

  // Checks on committed results
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic exe;
  assign exe = (state_r == S_EXE);

  chk_bitwise_xor: assert property (
    exe && op_r == XOR_OP && dstMd_r == MD_ACC |=> acc_r == ($past(dstB) ^ $past(srcB)))
    else $error("xor result wrong");
  chk_acc_modes_taken: assert property (
    cmdReady && cmdValid && cmdOp == OR_OP && dstMode == MD_ACC && srcMode == MD_IND
    |=> state_r == S_SPTR ##4 exe)
    else $error("accumulator logic form refused");
  chk_byte_dest_acc: assert property (
    exe && op_r inside {AND_OP, OR_OP, XOR_OP} && dstMd_r == MD_DIR
    |=> $stable(acc_r) && (toRam ? 1'b1 : sfrWrEn_r))
    else $error("byte logic touched accumulator");
  chk_rotate_left: assert property (
    exe && op_r == ROTATE_LEFT_OP
    |=> acc_r == {$past(acc_r) << 1} + {7'h00, $past(acc_r[BYTE_W-1])})
    else $error("left rotate wrong");
  chk_carry_rotate: assert property (
    exe && op_r == ROTATE_RIGHT_CARRY_OP
    |=> carry_r == $past(acc_r[0]) && acc_r[BYTE_W-1] == $past(carry_r))
    else $error("carry rotate wrong");
  chk_swap_only: assert property (
    exe && op_r == SWAP_NIBBLE_OP
    |=> acc_r[NIB_W-1:0] == $past(acc_r[BYTE_W-1:NIB_W]) && $stable(carry_r) && $stable(sp_r))
    else $error("nibble swap wrong");
  chk_clear_acc: assert property (
    exe && op_r == CLEAR_OP |=> acc_r == ACC_CLEAR && $stable(carry_r))
    else $error("clear failed");
  chk_transfer_keep: assert property (
    exe && op_r == TRANSFER_OP && dstMd_r != MD_ACC |=> $stable(acc_r))
    else $error("transfer changed accumulator");
  chk_sfr_direct: assert property (
    (sfrRdEn_r || sfrWrEn_r) |-> sfrAddr_r[UPPER_BIT])
    else $error("special-function access below upper half");
  chk_ind_ram: assert property (
    exe && dstMd_r == MD_IND && needWrite |-> ram.wrEn ##1 !sfrWrEn_r)
    else $error("indirect write left RAM");
  chk_stack_save: assert property (
    exe && op_r == STACK_SAVE_OP |-> ram.wrEn && ram.addr == spInc ##1 sp_r == $past(spInc))
    else $error("stack save order wrong");
  chk_stack_restore: assert property (
    state_r == S_SRD && op_r == STACK_RESTORE_OP |-> ram.addr == sp_r
    ##4 sp_r == $past(sp_r, 4) - SP_STEP)
    else $error("stack restore wrong");
  chk_dp_load: assert property (
    exe && op_r == LOAD_DATA_POINTER_OP |=> dp_r == $past(imm_r) && doneOut)
    else $error("data pointer load wrong");
  chk_exchange: assert property (
    exe && op_r == EXCHANGE_OP |-> memByte == acc_r ##1 acc_r == $past(dstB))
    else $error("exchange wrong");
  chk_low_nibble: assert property (
    exe && op_r == EXCHANGE_LOW_NIBBLE_OP
    |=> acc_r[BYTE_W-1:NIB_W] == $past(acc_r[BYTE_W-1:NIB_W]))
    else $error("low-nibble exchange touched high nibble");

  cov_stack_pair: cover property (
    exe && op_r == STACK_SAVE_OP ##[1:20] exe && op_r == STACK_RESTORE_OP);
  cov_sfr_write: cover property (sfrWrEn_r);
  cov_refused: cover property (errorOut);
endmodule
`default_nettype wire

// file: lim_pkg.sv
// Shared constants and types of the logic and internal-move datapath
package lim_pkg;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int NIB_W = 4;
  localparam int BANK_W = 2;
  localparam int REG_IDX_W = 3;
  localparam int RAM_BYTES = 256;
  // Direct addresses with this bit set fall in special-function space
  localparam int UPPER_BIT = 7;
  localparam logic [2:0] IND_REG_MASK = 3'h1;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] ACC_CLEAR = 8'h00;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] SP_STEP = 8'h01;
  localparam logic [15:0] DP_RESET = 16'h0000;
  localparam logic CARRY_RESET = 1'b0;

  typedef enum logic [3:0] {
    AND_OP, OR_OP, XOR_OP, CLEAR_OP, COMPLEMENT_OP, ROTATE_LEFT_OP,
    ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_OP, ROTATE_RIGHT_CARRY_OP, SWAP_NIBBLE_OP,
    TRANSFER_OP, STACK_SAVE_OP, STACK_RESTORE_OP, LOAD_DATA_POINTER_OP,
    EXCHANGE_OP, EXCHANGE_LOW_NIBBLE_OP
  } lim_op_t;

  // Operand location: MD_STK is only set internally by stack commands
  typedef enum logic [2:0] {
    MD_NONE, MD_ACC, MD_DIR, MD_IND, MD_REG, MD_IMM, MD_STK
  } lim_mode_t;
endpackage

// file: lim_ram_if.sv
// Internal data RAM port between the sequencer and the memory
`timescale 1ns/10ps
`default_nettype none
interface lim_ram_if
  import lim_pkg::*;
();
  logic [BYTE_W-1:0] addr;
  logic wrEn;
  logic [BYTE_W-1:0] wrData;
  logic [BYTE_W-1:0] rdData;
  modport ctrl (output addr, output wrEn, output wrData, input rdData);
  modport mem (input addr, input wrEn, input wrData, output rdData);
endinterface
`default_nettype wire

// file: lim_ram.sv
// Internal data RAM with registered read data
`timescale 1ns/10ps
`default_nettype none
module lim_ram
  import lim_pkg::*;
#(
  parameter int DEPTH = RAM_BYTES
) (
  input wire logic clk, // Core clock
  lim_ram_if.mem port // Sequencer access port
);
  logic [BYTE_W-1:0] cells [DEPTH];
  logic [BYTE_W-1:0] rdData_r;

  // Read returns the old byte on a same-cycle write; no reset, contents are data
  always_ff @(posedge clk) begin
    if (port.wrEn) begin
      cells[port.addr] <= port.wrData;
    end
    rdData_r <= cells[port.addr];
  end

  assign port.rdData = rdData_r;
endmodule
`default_nettype wire

// file: lim_datapath_bench.sv
// Self-checking bench of the logic and internal-move datapath
`timescale 1ns/10ps
`default_nettype none
module lim_datapath_bench
  import lim_pkg::*;
;
  logic clk, arstN, cmdValid, cmdReady, sfrRdEn, sfrWrEn, carryOut, doneOut, errorOut;
  lim_op_t cmdOp;
  lim_mode_t srcMode, dstMode;
  logic [7:0] srcVal, dstVal, sfrAddr, sfrWrData, accOut, stackPointerOut;
  logic [7:0] sfrRdData = 8'h00;
  logic [15:0] immWord, dataPointerOut;
  logic [1:0] bankSel;
  logic [7:0] sfrMem [256];
  logic [7:0] rdAddr = 8'h00;
  int rdCnt = 0;
  int sfrRdCount = 0;
  int nFail, comparisons;

  lim_datapath i_lim_datapath (.clk(clk), .arst_n(arstN), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOp(cmdOp), .srcMode(srcMode), .srcVal(srcVal),
    .dstMode(dstMode), .dstVal(dstVal), .immWord(immWord), .bankSel(bankSel),
    .sfrAddr(sfrAddr), .sfrRdEn(sfrRdEn), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
    .sfrRdData(sfrRdData), .accOut(accOut), .carryOut(carryOut),
    .stackPointerOut(stackPointerOut), .dataPointerOut(dataPointerOut),
    .doneOut(doneOut), .errorOut(errorOut));

  // 50 MHz core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Special-function space: read byte valid for the cycle after the strobe,
  // otherwise a toggling pattern so a stale value can never look right
  always @(negedge clk) begin
    if (sfrRdEn === 1'b1) begin
      rdAddr = sfrAddr;
      rdCnt = 2;
      sfrRdCount++;
    end
    if (rdCnt > 0) begin
      sfrRdData = sfrMem[rdAddr];
      rdCnt--;
    end else begin
      sfrRdData = ~sfrRdData;
    end
  end

  // Writes land in the model; indirect never reaches this space
  always @(posedge clk) begin
    if (sfrWrEn === 1'b1) begin
      sfrMem[sfrAddr] <= sfrWrData;
      check({8'h00, sfrAddr[7], 7'h00}, 16'h0080, "write below 80");
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One command, held until taken; waits for done under a bound, checks refusal one cycle after taking
  task automatic cmd(input lim_op_t op, input lim_mode_t sm, input logic [7:0] sv,
      input lim_mode_t dm, input logic [7:0] dv, input logic bad);
    int n;
    @(negedge clk);
    cmdValid = 1'b1;
    cmdOp = op;
    srcMode = sm;
    srcVal = sv;
    dstMode = dm;
    dstVal = dv;
    n = 0;
    // Ready is judged away from the taking edge, never in its time step
    while (cmdReady !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check({15'h0, cmdReady}, 16'h1, "ready to take");
    @(negedge clk);
    cmdValid = 1'b0;
    if (bad) begin
      check({15'h0, errorOut}, 16'h1, "refusal pulse");
      check({15'h0, cmdReady}, 16'h1, "ready after refusal");
    end else begin
      n = 0;
      while (doneOut !== 1'b1 && n < 20) begin
        @(negedge clk);
        n++;
      end
      check({15'h0, doneOut}, 16'h1, "completion");
    end
  endtask

  task automatic setAcc(input logic [7:0] v);
    cmd(TRANSFER_OP, MD_IMM, v, MD_ACC, 8'h00, 1'b0);
  endtask

  task automatic putDir(input logic [7:0] a, input logic [7:0] v);
    cmd(TRANSFER_OP, MD_IMM, v, MD_DIR, a, 1'b0);
  endtask

  task automatic getDir(input logic [7:0] a);
    cmd(TRANSFER_OP, MD_DIR, a, MD_ACC, 8'h00, 1'b0);
  endtask

  task automatic t_logic_acc();
    lim_op_t ops [3] = '{AND_OP, OR_OP, XOR_OP};
    lim_mode_t md [4] = '{MD_DIR, MD_IND, MD_REG, MD_IMM};
    logic [7:0] sv [4] = '{8'h30, 8'h01, 8'h06, 8'h53};
    logic [7:0] ex [3] = '{8'h11, 8'h77, 8'h66};
    putDir(8'h30, 8'h53);
    putDir(8'h01, 8'h40);
    putDir(8'h40, 8'h53);
    putDir(8'h06, 8'h53);
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 4; j++) begin
        setAcc(8'h35);
        cmd(ops[i], md[j], sv[j], MD_ACC, 8'h00, 1'b0);
        check({8'h00, accOut}, {8'h00, ex[i]}, "logic into acc");
      end
    end
  endtask

  task automatic t_logic_dir();
    putDir(8'h31, 8'h0f);
    setAcc(8'h3c);
    cmd(AND_OP, MD_ACC, 8'h00, MD_DIR, 8'h31, 1'b0);
    check({8'h00, accOut}, 16'h003c, "acc kept");
    cmd(OR_OP, MD_IMM, 8'h81, MD_DIR, 8'h31, 1'b0);
    sfrMem[8'h90] = 8'ha5;
    cmd(XOR_OP, MD_IMM, 8'hff, MD_DIR, 8'h90, 1'b0);
    getDir(8'h31);
    check({8'h00, accOut}, 16'h008d, "logic into byte");
    check({8'h00, sfrMem[8'h90]}, 16'h005a, "invert special byte");
  endtask

  task automatic t_accops();
    lim_op_t ops [7] = '{ROTATE_LEFT_OP, ROTATE_RIGHT_OP, ROTATE_LEFT_CARRY_OP,
      SWAP_NIBBLE_OP, ROTATE_RIGHT_CARRY_OP, COMPLEMENT_OP, CLEAR_OP};
    logic [7:0] ex [7] = '{8'h2d, 8'h96, 8'h2c, 8'hc2, 8'he1, 8'h1e, 8'h00};
    logic cy [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    setAcc(8'h96);
    for (int i = 0; i < 7; i++) begin
      cmd(ops[i], MD_NONE, 8'h00, MD_NONE, 8'h00, 1'b0);
      check({8'h00, accOut}, {8'h00, ex[i]}, "acc-only op");
      check({15'h0, carryOut}, {15'h0, cy[i]}, "carry");
    end
    check({8'h00, stackPointerOut}, 16'h0007, "pointer untouched");
  endtask

  task automatic t_move();
    int n;
    setAcc(8'h77);
    cmd(TRANSFER_OP, MD_DIR, 8'h30, MD_DIR, 8'h32, 1'b0);
    check({8'h00, accOut}, 16'h0077, "transfer bypasses acc");
    getDir(8'h32);
    check({8'h00, accOut}, 16'h0053, "transfer copy");
    putDir(8'h00, 8'hc0);
    cmd(TRANSFER_OP, MD_IMM, 8'hc3, MD_IND, 8'h00, 1'b0);
    sfrMem[8'hc0] = 8'he1;
    getDir(8'hc0);
    check({8'h00, accOut}, 16'h00e1, "direct upper is special");
    n = sfrRdCount;
    cmd(TRANSFER_OP, MD_IND, 8'h00, MD_ACC, 8'h00, 1'b0);
    check({8'h00, accOut}, 16'h00c3, "indirect upper ram");
    check(16'(sfrRdCount), 16'(n), "indirect read strobe");
    cmd(TRANSFER_OP, MD_DIR, 8'hc0, MD_DIR, 8'h91, 1'b0);
    getDir(8'h32);
    check({8'h00, sfrMem[8'h91]}, 16'h00e1, "special to special");
  endtask

  task automatic t_stack();
    cmd(STACK_SAVE_OP, MD_DIR, 8'h30, MD_NONE, 8'h00, 1'b0);
    check({8'h00, stackPointerOut}, 16'h0008, "save increments");
    getDir(8'h08);
    check({8'h00, accOut}, 16'h0053, "saved at new pointer");
    cmd(STACK_RESTORE_OP, MD_NONE, 8'h00, MD_DIR, 8'h33, 1'b0);
    check({8'h00, stackPointerOut}, 16'h0007, "restore decrements");
    getDir(8'h33);
    check({8'h00, accOut}, 16'h0053, "restored byte");
    sfrMem[8'ha0] = 8'h4e;
    cmd(STACK_SAVE_OP, MD_DIR, 8'ha0, MD_NONE, 8'h00, 1'b0);
    cmd(STACK_RESTORE_OP, MD_NONE, 8'h00, MD_DIR, 8'hb0, 1'b0);
    check({8'h00, stackPointerOut}, 16'h0007, "pointer back");
    getDir(8'h08);
    check({8'h00, accOut}, 16'h004e, "stack in ram");
    check({8'h00, sfrMem[8'hb0]}, 16'h004e, "direct special operand");
  endtask

  task automatic t_data_pointer();
    logic [15:0] v [2] = '{16'hbeef, 16'h1234};
    for (int i = 0; i < 2; i++) begin
      immWord = v[i];
      cmd(LOAD_DATA_POINTER_OP, MD_NONE, 8'h00, MD_NONE, 8'h00, 1'b0);
      check(dataPointerOut, v[i], "data pointer load");
    end
  endtask

  task automatic t_exch();
    putDir(8'h34, 8'hab);
    setAcc(8'h12);
    cmd(EXCHANGE_OP, MD_NONE, 8'h00, MD_DIR, 8'h34, 1'b0);
    check({8'h00, accOut}, 16'h00ab, "exchange acc");
    getDir(8'h34);
    check({8'h00, accOut}, 16'h0012, "exchange byte");
    setAcc(8'ha7);
    cmd(EXCHANGE_LOW_NIBBLE_OP, MD_NONE, 8'h00, MD_IND, 8'h01, 1'b0);
    check({8'h00, accOut}, 16'h00a3, "nibble exchange acc");
    cmd(TRANSFER_OP, MD_IND, 8'h01, MD_ACC, 8'h00, 1'b0);
    check({8'h00, accOut}, 16'h0057, "nibble exchange byte");
    bankSel = 2'h1;
    putDir(8'h0a, 8'h66);
    setAcc(8'h99);
    cmd(EXCHANGE_OP, MD_NONE, 8'h00, MD_REG, 8'h02, 1'b0);
    check({8'h00, accOut}, 16'h0066, "exchange register");
    getDir(8'h0a);
    check({8'h00, accOut}, 16'h0099, "register in bank one");
    bankSel = 2'h0;
  endtask

  // Illegal operand combinations must be refused and leave state alone
  task automatic t_refuse();
    setAcc(8'h5a);
    cmd(AND_OP, MD_DIR, 8'h30, MD_DIR, 8'h31, 1'b1);
    cmd(STACK_RESTORE_OP, MD_NONE, 8'h00, MD_ACC, 8'h00, 1'b1);
    cmd(EXCHANGE_LOW_NIBBLE_OP, MD_NONE, 8'h00, MD_DIR, 8'h34, 1'b1);
    check({8'h00, accOut}, 16'h005a, "acc after refusals");
    getDir(8'h31);
    check({8'h00, accOut}, 16'h008d, "byte after refusal");
  endtask

  task automatic conclude();
    if (nFail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard, well above the 76 commands of the run
  initial begin
    #200000;
    nFail++;
    conclude();
  end

  // Main sequence
  initial begin
    arstN = 1'b0;
    cmdValid = 1'b0;
    cmdOp = AND_OP;
    srcMode = MD_NONE;
    dstMode = MD_NONE;
    srcVal = 8'h00;
    dstVal = 8'h00;
    immWord = 16'h0000;
    bankSel = 2'h0;
    nFail = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check({accOut, stackPointerOut}, 16'h0007, "reset acc and pointer");
    check(dataPointerOut, 16'h0000, "reset data pointer");
    check({12'h0, carryOut, doneOut, errorOut, cmdReady}, 16'h0001, "reset flags");
    arstN = 1'b1;
    t_logic_acc();
    t_logic_dir();
    t_accops();
    t_move();
    t_stack();
    t_data_pointer();
    t_exch();
    t_refuse();
    conclude();
  end
endmodule
`default_nettype wire
